// file: bench/stop_wake_watchdog_config_test.sv
// register and stop/wake sequences for the wake/watchdog block
// assumes swwc_core and the pin model swwc_pins
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module stop_wake_watchdog_config_test;
  // design inputs, set at time zero
  logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, enter_stop = 1'b0;
  logic       halt_mode = 1'b0, wdog_reset = 1'b0, wdog_timeout = 1'b0, analog_en = 1'b0;
  logic [3:0] rp_bank = 4'hf, pat3 = 4'h0, p3_in;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, p2_out = 8'h00, p2_dir_out = 8'h00;
  logic [7:0] pat2 = 8'h00, p2_in, reg_rdata, p;
  logic       fire = 1'b0, stop_on = 1'b1;
  logic       wake_pulse, wake_delay, in_stop, clk_div16, sys_clk_xtal_div, wdog_clk_xtal, wdog_run;
  logic [1:0] wdog_tap;
  int         errors = 0;
  int         n_checks = 0;
  always #20 sys_clk = ~sys_clk;
  swwc_core swwc_core_inst (.sys_clk, .rst, .rp_bank, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .enter_stop, .halt_mode, .wdog_reset, .wdog_timeout, .p2_in, .p2_out, .p2_dir_out, .p3_in, .analog_en,
    .wake_pulse, .wake_delay, .in_stop, .clk_div16, .sys_clk_xtal_div, .wdog_clk_xtal, .wdog_run, .wdog_tap);
  swwc_pins swwc_pins_inst (.sys_clk, .rst, .fire, .pat2, .pat3, .p2_in, .p3_in);
  // ****************************************
  // access tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  // read data is registered, so it is settled at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    `CHK(n, e, reg_rdata)
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  // one stop/wake round; a missing expected wake ends the run, any other missing wake is ended by a watchdog timeout
  task automatic sleep(input logic [7:0] one, input logic [1:0] two, input logic [7:0] pa2,
                       input logic [3:0] pa3, input logic exp_wake);
    logic hit;
    hit = 1'b0;
    wr(8'h0b, one);
    wr(8'h0d, {6'h00, two});
    pat2 = pa2;
    pat3 = pa3;
    pulse(fire);
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      if (wake_pulse !== 1'b0) hit = 1'b1;
    end
    `CHK("run_wake", 1'b0, hit)
    pulse(enter_stop);
    `CHK("in_stop", 1'b1, in_stop)
    `CHK("wdog_run_stop", stop_on, wdog_run)
    rd(8'h0b, 8'h80, "flag_set");
    pulse(fire);
    for (int i = 0; i < 10 && !hit; i++) begin
      hit = (wake_pulse === 1'b1);
      if (!hit) @(negedge sys_clk);
    end
    `CHK("wake", exp_wake, hit)
    if (exp_wake && !hit) give_verdict();
    if (!hit) begin
      pulse(wdog_timeout);
      hit = (wake_pulse === 1'b1);
    end
    `CHK("wake_pulse", 1'b1, hit)
    `CHK("wake_delay", exp_wake ? one[5] : 1'b1, wake_delay)
    `CHK("div_cleared", 1'b0, clk_div16)
    `CHK("awake", 1'b0, in_stop)
    rd(8'h0b, 8'h80, "flag_warm");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    `CHK("rst_delay", 1'b1, wake_delay)
    `CHK("rst_div", 2'b00, {clk_div16, sys_clk_xtal_div})
    `CHK("rst_wdog", 4'b0101, {wdog_clk_xtal, wdog_run, wdog_tap})
    rd(8'h0b, 8'h00, "flag_cold");
    rd(8'h0f, 8'h00, "wdog_wo");
    wr(8'h0b, 8'h03);
    `CHK("div_on", 2'b11, {clk_div16, sys_clk_xtal_div})
    rd(8'h0b, 8'h00, "wo_bits");
    rp_bank = 4'h0;
    wr(8'h0b, 8'h00);
    `CHK("other_bank", 1'b1, clk_div16)
    rp_bank = 4'hf;
    // watchdog taps and clock select, halt disabled
    for (int t = 0; t < 4; t++) begin
      wr(8'h0f, {3'h0, t[0], 2'b10, t[1:0]});
      `CHK("tap", t[1:0], wdog_tap)
      `CHK("wd_xtal", t[0], wdog_clk_xtal)
      halt_mode = 1'b1;
      @(negedge sys_clk);
      `CHK("wd_halt", 1'b0, wdog_run)
      halt_mode = 1'b0;
    end
    // stop disabled, no source: only the timeout wakes, with delay forced
    wr(8'h0f, 8'h05);
    stop_on = 1'b0;
    sleep(8'h81, 2'h0, 8'hff, 4'hf, 1'b0);
    wr(8'h0f, 8'h0d);
    stop_on = 1'b1;
    // every first-register source at both levels
    for (int lv = 0; lv < 2; lv++) begin
      for (int c = 1; c < 8; c++) begin
        p = (c >= 6) ? {8{~lv[0]}} : {8{lv[0]}};
        sleep({1'b0, lv[0], c[0], c[2:0], 2'b01}, 2'h0, p, {4{lv[0]}}, 1'b1);
      end
    end
    // second register with the first field zeroed; half-high port separates the two ANDs
    for (int k = 1; k < 4; k++) sleep(8'he1, k[1:0], 8'h0f, 4'hf, k == 1);
    sleep(8'h61, 2'h2, 8'hff, 4'h0, 1'b1);
    analog_en = 1'b1;
    for (int c = 2; c < 5; c++) sleep({1'b0, 2'b11, c[2:0], 2'b01}, 2'h0, 8'hff, 4'hf, 1'b0);
    analog_en = 1'b0;
    // port 2 as output low: the pin input must not wake
    p2_dir_out = 8'hff;
    sleep(8'hf5, 2'h0, 8'hff, 4'hf, 1'b0);
    p2_dir_out = 8'h00;
    pulse(wdog_reset);
    rd(8'h0b, 8'h00, "flag_wdog");
    // move the watchdog fields off their reset values so the reset below shows
    wr(8'h0f, 8'h12);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    `CHK("rerst", 5'b10101, {wake_delay, wdog_clk_xtal, wdog_run, wdog_tap})
    give_verdict();
  end
endmodule

// file: bench/swwc_pins.sv
// pin-side model of the wake sources on ports 2 and 3
// assumes the bench pulses fire for one cycle with the pattern to show
`timescale 1ns/1ps
module swwc_pins (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // request from the bench
  input  wire logic       fire,
  input  wire logic [7:0] pat2,
  input  wire logic [3:0] pat3,
  // pins
  output logic      [7:0] p2_in,
  output logic      [3:0] p3_in
);
  logic [2:0] hold;
  logic [2:0] next_hold;
  // hold the source six cycles, one past the fast-wake minimum
  always_comb begin
    next_hold = fire ? 3'h6 : ((hold != 3'h0) ? hold - 3'h1 : 3'h0);
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) hold <= 3'h0;
    else hold <= next_hold;
  end
  // idle shows the inverse, so a stale level never looks like a wake
  assign p2_in = (hold != 3'h0) ? pat2 : ~pat2;
  assign p3_in = (hold != 3'h0) ? pat3 : ~pat3;
endmodule

// file: logic/swwc_core.sv
// wake-source selection, start-type flag, clock divide and watchdog configuration
// assumes core strobes, port pins and sys_clk are synchronous; rst is the power-on reset
`timescale 1ns/1ps
`include "swwc_map.svh"
module swwc_core (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // register access from the core
  input  wire logic [3:0] rp_bank,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // core power state and events
  input  wire logic       enter_stop,
  input  wire logic       halt_mode,
  input  wire logic       wdog_reset,
  input  wire logic       wdog_timeout,
  // port pins
  input  wire logic [7:0] p2_in,
  input  wire logic [7:0] p2_out,
  input  wire logic [7:0] p2_dir_out,
  input  wire logic [3:0] p3_in,
  input  wire logic       analog_en,
  // results
  output logic            wake_pulse,
  output logic            wake_delay,
  output logic            in_stop,
  output logic            clk_div16,
  output logic            sys_clk_xtal_div,
  output logic            wdog_clk_xtal,
  output logic            wdog_run,
  output logic      [1:0] wdog_tap
);
  // ****************************************
  // storage
  // ****************************************
  swwc_pkg::swwc_wake_one_t wake_one, next_wake_one;
  swwc_pkg::swwc_wdog_t     wdog, next_wdog;
  swwc_pkg::swwc_state_t    state, next_state;
  logic [1:0] wake_two, next_wake_two;
  logic       flag, next_flag;
  logic [7:0] next_rdata;
  logic       next_wake_pulse, next_wake_delay, next_wdog_run;
  logic [7:0] p2_eff;
  logic       src_one, src_two, hit, wd_wake, sel;

  // ****************************************
  // pin sampling
  // ****************************************
  // output pins feed back their own driven level
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_p2
      assign p2_eff[gi] = p2_dir_out[gi] ? p2_out[gi] : p2_in[gi];
    end
  endgenerate

  // ****************************************
  // wake source decode
  // ****************************************
  // level sources compare against the level bit; one sample is taken per clock, so a
  // fast wake depends on the source staying active several periods
  always_comb begin
    unique case (wake_one.src)
      3'h1:    src_one = (p3_in[0] == wake_one.level);
      3'h2:    src_one = !analog_en && (p3_in[1] == wake_one.level);
      3'h3:    src_one = !analog_en && (p3_in[2] == wake_one.level);
      3'h4:    src_one = !analog_en && (p3_in[3] == wake_one.level);
      3'h5:    src_one = (p2_eff[7] == wake_one.level);
      3'h6:    src_one = ((~|p2_eff[3:0]) == wake_one.level);
      3'h7:    src_one = ((~|p2_eff) == wake_one.level);
      default: src_one = 1'b0; // code 0: no source selected, the reset value
    endcase
    // second register shares the level bit; code 11 is reserved and wakes nothing
    unique case (wake_two)
      2'h1:    src_two = ((&p2_eff[3:0]) == wake_one.level);
      2'h2:    src_two = ((&p2_eff) == wake_one.level);
      default: src_two = 1'b0;
    endcase
  end

  // the two selections are simply ORed; firmware keeps one of them at zero
  assign hit     = (src_one || src_two) && (state == swwc_pkg::SWWC_STOP);
  assign wd_wake = wdog_timeout && (state == swwc_pkg::SWWC_STOP);
  assign sel     = (rp_bank == `SWWC_BANK_CFG) && (reg_addr[7:4] == 4'h0);

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_wake_one   = wake_one;
    next_wdog       = wdog;
    next_wake_two   = wake_two;
    next_state      = state;
    next_flag       = flag;
    next_rdata      = 8'h00;
    next_wake_pulse = 1'b0;
    next_wake_delay = wake_delay;
    // writes: reserved bits are dropped
    if (reg_wr && sel && reg_addr[3:0] == `SWWC_OFS_WAKE_ONE) begin
      next_wake_one = reg_wdata[`SWWC_B_LEVEL:`SWWC_B_DIV];
    end
    if (reg_wr && sel && reg_addr[3:0] == `SWWC_OFS_WAKE_TWO) begin
      next_wake_two = reg_wdata[1:0];
    end
    if (reg_wr && sel && reg_addr[3:0] == `SWWC_OFS_WDOG) begin
      next_wdog = reg_wdata[`SWWC_B_WD_XTAL:0];
    end
    // reads show only the flag; write-only places read zero
    if (reg_rd && sel && reg_addr[3:0] == `SWWC_OFS_WAKE_ONE) begin
      next_rdata = {flag, 7'h00};
    end
    // a watchdog reset is a cold start unless a stop entry or a wake sets the flag in the same cycle
    if (wdog_reset) begin
      next_flag = 1'b0;
    end
    unique case (state)
      swwc_pkg::SWWC_RUN: begin
        if (enter_stop) begin
          next_state = swwc_pkg::SWWC_STOP;
          next_flag  = 1'b1; // set wins over a same-cycle clear
        end
      end
      swwc_pkg::SWWC_STOP: begin
        if (hit || wd_wake) begin
          next_state        = swwc_pkg::SWWC_RUN;
          next_wake_pulse   = 1'b1;
          next_flag         = 1'b1; // warm start
          next_wake_delay   = wake_one.delay || wd_wake;
          next_wake_one.div = 1'b0;
        end
      end
    endcase
    // watchdog gated by power state
    next_wdog_run = !((next_state == swwc_pkg::SWWC_STOP) && !next_wdog.stop_en)
                 && !(halt_mode && !next_wdog.halt_en);
  end

  // ****************************************
  // registers
  // ****************************************
  // every output is a flop so the core sees clean levels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_one   <= 7'(`SWWC_RST_WAKE_ONE); // flag place is not stored here
      wdog       <= `SWWC_RST_WDOG;
      wake_two   <= `SWWC_RST_WAKE_TWO;
      state      <= swwc_pkg::SWWC_RUN;
      flag       <= 1'b0;
      reg_rdata  <= 8'h00;
      wake_pulse <= 1'b0;
      wake_delay <= 1'b1;
      wdog_run   <= 1'b1;
    end else begin
      wake_one   <= next_wake_one;
      wdog       <= next_wdog;
      wake_two   <= next_wake_two;
      state      <= next_state;
      flag       <= next_flag;
      reg_rdata  <= next_rdata;
      wake_pulse <= next_wake_pulse;
      wake_delay <= next_wake_delay;
      wdog_run   <= next_wdog_run;
    end
  end

  assign in_stop          = state[1];
  assign clk_div16        = wake_one.div;
  assign sys_clk_xtal_div = wake_one.external_clock_divide;
  assign wdog_clk_xtal    = wdog.xtal;
  assign wdog_tap         = wdog.tap;

  // ****************************************
  // checks
  // ****************************************
  property p_flag_set;
    @(posedge sys_clk) disable iff (rst) (state == swwc_pkg::SWWC_RUN && enter_stop) |=> flag && in_stop;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on stop entry");
  property p_cold;
    @(posedge sys_clk) disable iff (rst) (wdog_reset && !enter_stop && !in_stop) |=> !flag;
  endproperty
  a_cold: assert property (p_cold) else $error("flag not cleared by watchdog reset");
  property p_div_clear;
    @(posedge sys_clk) disable iff (rst) wake_pulse |-> !clk_div16 && !in_stop;
  endproperty
  a_div_clear: assert property (p_div_clear) else $error("divider kept after wake");
  property p_no_wake_run;
    @(posedge sys_clk) disable iff (rst) (!in_stop) |=> !wake_pulse;
  endproperty
  a_no_wake_run: assert property (p_no_wake_run) else $error("wake outside stop");
  property p_wd_delay;
    @(posedge sys_clk) disable iff (rst) (in_stop && wdog_timeout) |=> wake_pulse && wake_delay && flag;
  endproperty
  a_wd_delay: assert property (p_wd_delay) else $error("watchdog wake without delay");
  property p_delay_sel;
    @(posedge sys_clk) disable iff (rst) (in_stop && hit && !wdog_timeout) |=> wake_delay == $past(wake_one.delay);
  endproperty
  a_delay_sel: assert property (p_delay_sel) else $error("delay select ignored");
  property p_read;
    @(posedge sys_clk) disable iff (rst) (reg_rd && sel) |=> reg_rdata[6:0] == 7'h00 && reg_rdata[7] == $past(flag)
      || $past(reg_addr[3:0]) != `SWWC_OFS_WAKE_ONE;
  endproperty
  a_read: assert property (p_read) else $error("write-only bits visible");
  property p_wd_stop;
    @(posedge sys_clk) disable iff (rst) (in_stop && !wdog.stop_en) |-> !wdog_run;
  endproperty
  a_wd_stop: assert property (p_wd_stop) else $error("watchdog runs in stop");
  property p_analog;
    @(posedge sys_clk) disable iff (rst) (in_stop && analog_en && wake_two == 2'h0 && !wdog_timeout
      && (wake_one.src == 3'h2 || wake_one.src == 3'h3 || wake_one.src == 3'h4)) |=> !wake_pulse;
  endproperty
  a_analog: assert property (p_analog) else $error("comparator pin woke part");
  c_src_wake: cover property (@(posedge sys_clk) disable iff (rst) in_stop && hit);
  c_wd_wake: cover property (@(posedge sys_clk) disable iff (rst) wd_wake);
  c_two_wake: cover property (@(posedge sys_clk) disable iff (rst) in_stop && src_two);
endmodule

// file: logic/swwc_map.svh
// offsets, field positions, reset values and timing counts of the wake/watchdog block
// assumes the includer needs plain macros only
`ifndef SWWC_MAP_SVH
`define SWWC_MAP_SVH
// ****************************************
// register map inside expanded bank
// ****************************************
`define SWWC_BANK_CFG      4'hf
`define SWWC_OFS_WAKE_ONE  4'hb
`define SWWC_OFS_WAKE_TWO  4'hd
`define SWWC_OFS_WDOG      4'hf
// ****************************************
// field positions
// ****************************************
`define SWWC_B_FLAG        7
`define SWWC_B_LEVEL       6
`define SWWC_B_DELAY       5
`define SWWC_B_SRC_HI      4
`define SWWC_B_SRC_LO      2
`define SWWC_B_EXTERNAL_CLOCK_DIVIDE      1
`define SWWC_B_DIV         0
`define SWWC_B_WD_XTAL     4
`define SWWC_B_WD_STOP     3
`define SWWC_B_WD_HALT     2
// ****************************************
// reset values
// ****************************************
`define SWWC_RST_WAKE_ONE  8'h20
`define SWWC_RST_WAKE_TWO  2'h0
`define SWWC_RST_WDOG      5'h0d
// ****************************************
// watchdog timeouts in system clocks, per tap code
// ****************************************
`define SWWC_WD_CLKS_0     12'h080
`define SWWC_WD_CLKS_1     12'h100
`define SWWC_WD_CLKS_2     12'h200
`define SWWC_WD_CLKS_3     12'h800
`endif

// file: logic/swwc_pkg.sv
// types of the wake/watchdog configuration block
// assumes swwc_map.svh holds the numbers
package swwc_pkg;
  // first wake register, writable part
  typedef struct packed {
    logic       level;
    logic       delay;
    logic [2:0] src;
    logic       external_clock_divide;
    logic       div;
  } swwc_wake_one_t;
  // watchdog mode, writable part
  typedef struct packed {
    logic       xtal;
    logic       stop_en;
    logic       halt_en;
    logic [1:0] tap;
  } swwc_wdog_t;
  // run/stop state, one-hot
  typedef enum logic [1:0] {
    SWWC_RUN  = 2'b01,
    SWWC_STOP = 2'b10
  } swwc_state_t;
endpackage
